/* rtl/ptfc_pkg.sv */
// constants and types shared by the pasid translation fault checker
package ptfc_pkg;
   localparam int          REG_AW          = 5;
   localparam logic [4:0]  REG_RTP_LO      = 5'h00;
   localparam logic [4:0]  REG_RTP_HI      = 5'h04;
   localparam logic [4:0]  REG_STATUS      = 5'h08;
   localparam logic [4:0]  REG_MASK        = 5'h0C;
   localparam logic [4:0]  REG_LAST        = 5'h10;
   localparam int          RTP_KIND_BIT    = 11;
   localparam int          IRQ_W           = 3;
   localparam int          EV_UR           = 0;
   localparam int          EV_CA           = 1;
   localparam int          EV_DONE         = 2;
   localparam logic [2:0]  IRQ_RST         = 3'h0;
   localparam logic [31:0] RTP_RST         = 32'h0;
   localparam logic [1:0]  AT_XLATE_REQ    = 2'h1;
   localparam logic [1:0]  CPL_SC          = 2'h0;
   localparam logic [1:0]  CPL_UR          = 2'h1;
   localparam logic [1:0]  CPL_CA          = 2'h2;
   localparam logic [7:0]  RSN_NONE        = 8'h00;
   localparam logic [7:0]  RSN_ROOT_NP     = 8'h01;
   localparam logic [7:0]  RSN_CTX_NP      = 8'h02;
   localparam logic [7:0]  RSN_CTX_PROG    = 8'h03;
   localparam logic [7:0]  RSN_SL_ERR      = 8'h07;
   localparam logic [7:0]  RSN_ROOT_ERR    = 8'h08;
   localparam logic [7:0]  RSN_CTX_ERR     = 8'h09;
   localparam logic [7:0]  RSN_ROOT_RSV    = 8'h0A;
   localparam logic [7:0]  RSN_BLOCKED     = 8'h0D;
   localparam logic [7:0]  RSN_PID_OFF     = 8'h10;
   localparam logic [7:0]  RSN_PID_BIG     = 8'h11;
   localparam logic [7:0]  RSN_EXEC        = 8'h19;
   localparam logic [7:0]  RSN_SUPV        = 8'h1A;
   localparam logic [7:0]  RSN_LEGACY      = 8'h1B;
   localparam int          PRESENT_BIT     = 0;
   localparam int          ROOT_RSV_HI     = 11;
   localparam int          PTR_LSB         = 12;
   localparam int          CTX_T_LSB       = 2;
   localparam logic [2:0]  T_PLAIN         = 3'h1;
   localparam logic [2:0]  T_NESTED        = 3'h5;
   localparam int          CTX_AW_LSB      = 0;
   localparam int          CTX_PIDE_BIT    = 3;
   localparam int          CTX_ERE_BIT     = 4;
   localparam int          CTX_PTS_LSB     = 5;
   localparam int          PTE_SRE_BIT     = 1;
   localparam int          PTS_BASE_SHIFT  = 5;
   localparam int          PASID_W         = 20;
   localparam int          SL_IDX_W        = 9;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ROOT, ST_CTX, ST_PTE, ST_SLW
   } ptfc_state_e;
endpackage

/* rtl/ptfc_pasid_limit.sv */
// compares a process identifier against the process-table size limit
`timescale 1ns/1ns
module ptfc_pasid_limit
(
   input  wire logic [3:0]                   process_table_size,
   input  wire logic [ptfc_pkg::PASID_W-1:0] pasid,
   output logic                              too_big
);
   import ptfc_pkg::*;

   logic [4:0] shamt;

   // table holds 2^(pts+5) entries; sizes past the id width never overflow
   always_comb
   begin
      shamt   = 5'(process_table_size) + 5'(PTS_BASE_SHIFT);
      too_big = 1'b0;
      if (shamt < 5'(PASID_W))
      begin
         too_big = |(pasid >> shamt);
      end
   end
endmodule // ptfc_pasid_limit

/* rtl/ptfc_irq.sv */
// sticky event status, mask and level interrupt
`timescale 1ns/1ns
module ptfc_irq
#(
   parameter int W = 3
)
(
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] events,
   input  wire logic         wr_status,
   input  wire logic         wr_mask,
   input  wire logic [W-1:0] wdata,
   output logic      [W-1:0] status,
   output logic      [W-1:0] mask,
   output logic              irq
);
   import ptfc_pkg::*;

   // a new event beats a write-one-to-clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         status <= W'(IRQ_RST);
      end
      else
      begin
         status <= (status & ~(wr_status ? wdata : '0)) | events;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         mask <= W'(IRQ_RST);
      end
      else if (wr_mask)
      begin
         mask <= wdata;
      end
   end

   assign irq = |(status & mask);
endmodule // ptfc_irq

/* rtl/ptfc_top.sv */
// fault classifier for translation requests carrying a process id
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module ptfc_top
#(
   parameter int         HAW_BITS       = 39,
   parameter logic [4:0] AW_SUPPORTED   = 5'h06,
   parameter bit         NEST_SUPPORTED = 1'b1
)
(
   input  wire logic                           sys_clk,
   input  wire logic                           nrst,
   input  wire logic [ptfc_pkg::REG_AW-1:0]    reg_addr,
   input  wire logic [31:0]                    reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [31:0]                    reg_rdata,
   output logic                                irq,
   input  wire logic                           req_valid,
   output logic                                req_ready,
   input  wire logic [1:0]                     req_addr_type,
   input  wire logic                           req_pasid_present,
   input  wire logic [ptfc_pkg::PASID_W-1:0]   req_pasid,
   input  wire logic [15:0]                    req_rid,
   input  wire logic                           req_exec,
   input  wire logic                           req_priv,
   input  wire logic [63:0]                    req_addr,
   output logic                                mem_rd_valid,
   output logic      [63:0]                    mem_rd_addr,
   input  wire logic                           mem_rsp_valid,
   input  wire logic [63:0]                    mem_rsp_data,
   input  wire logic                           mem_rsp_err,
   output logic                                cpl_valid,
   output logic      [1:0]                     cpl_status,
   output logic                                fault_valid,
   output logic      [7:0]                     fault_reason,
   output logic                                fault_qualified,
   output logic      [15:0]                    fault_rid,
   output logic      [ptfc_pkg::PASID_W-1:0]   fault_pasid
);
   import ptfc_pkg::*;

   if (HAW_BITS < 32 || HAW_BITS > 63)
   begin : g_bad_haw
      $error("ptfc_top: HAW_BITS must lie in 32..63");
   end

   function automatic logic [1:0] status_of(input logic [7:0] rsn);
      case (rsn)
         RSN_NONE:
            status_of = CPL_SC;
         RSN_ROOT_NP, RSN_LEGACY, RSN_CTX_NP, RSN_BLOCKED,
         RSN_PID_OFF, RSN_PID_BIG, RSN_EXEC, RSN_SUPV:
            status_of = CPL_UR;
         default:
            status_of = CPL_CA;
      endcase
   endfunction

   function automatic logic qualified_of(input logic [7:0] rsn);
      case (rsn)
         RSN_NONE, RSN_ROOT_NP, RSN_LEGACY, RSN_ROOT_ERR,
         RSN_CTX_ERR, RSN_ROOT_RSV:
            qualified_of = 1'b0;
         default:
            qualified_of = 1'b1;
      endcase
   endfunction

   ptfc_state_e                st;
   ptfc_state_e                next_st;
   logic [31:0]                rtp_lo;
   logic [31:0]                rtp_hi;
   logic [15:0]                rq_rid;
   logic [PASID_W-1:0]         rq_pasid;
   logic                       rq_exec;
   logic                       rq_priv;
   logic [63:0]                rq_addr;
   logic [63:0]                ctx0;
   logic [63:0]                ctx_ptr;
   logic                       widx;
   logic [2:0]                 lvl;
   logic                       sl_first;
   logic                       fin;
   logic [7:0]                 next_reason;
   logic                       fetch;
   logic [63:0]                next_addr;
   logic [2:0]                 next_lvl;
   logic [63:0]                root_base;
   logic [63:0]                root_addr;
   logic [63:0]                pte_addr;
   logic [63:0]                sl_addr;
   logic [2:0]                 aw_fld;
   logic [2:0]                 t_fld;
   logic                       pid_big;
   logic [15:0]                cur_rid;
   logic [PASID_W-1:0]         cur_pasid;
   logic [7:0]                 last_reason;
   logic [1:0]                 last_status;
   logic [IRQ_W-1:0]           irq_events;
   logic [IRQ_W-1:0]           irq_status;
   logic [IRQ_W-1:0]           irq_mask;
   logic                       take;

   assign req_ready = (st == ST_IDLE);
   assign take      = req_valid && req_ready;
   assign root_base = {rtp_hi, rtp_lo[31:PTR_LSB], 12'h000};
   // one 64-bit half per root slot: low half for devfn 0..127
   assign root_addr = root_base + 64'({req_rid[15:8], req_rid[7], 3'h0});
   assign t_fld     = ctx0[CTX_T_LSB +: 3];
   assign aw_fld    = mem_rsp_data[CTX_AW_LSB +: 3];
   assign pte_addr  = {mem_rsp_data[63:PTR_LSB], 12'h000}
                      + 64'({rq_pasid, 3'h0});
   // each returned entry points one level below the index it was fetched at
   assign sl_addr   = {mem_rsp_data[63:PTR_LSB], 12'h000}
                      + 64'({rq_addr[PTR_LSB + SL_IDX_W * (lvl - 3'h1)
                                     +: SL_IDX_W], 3'h0});
   assign cur_rid   = (st == ST_IDLE) ? req_rid : rq_rid;
   assign cur_pasid = (st == ST_IDLE) ? req_pasid : rq_pasid;

   ptfc_pasid_limit u_limit
   (
      .process_table_size   (mem_rsp_data[CTX_PTS_LSB +: 4]),
      .pasid (rq_pasid),
      .too_big (pid_big)
   );

   // one fetch in flight at a time; each response decides the next step
   always_comb
   begin
      next_st     = st;
      next_reason = RSN_NONE;
      fin         = 1'b0;
      fetch       = 1'b0;
      next_addr   = 64'h0;
      next_lvl    = lvl;
      case (st)
         ST_IDLE:
         begin
            if (take)
            begin
               if (req_addr_type != AT_XLATE_REQ || !req_pasid_present)
               begin
                  fin = 1'b1;
               end
               else if (!rtp_lo[RTP_KIND_BIT])
               begin
                  fin         = 1'b1;
                  next_reason = RSN_LEGACY;
               end
               else
               begin
                  fetch     = 1'b1;
                  next_addr = root_addr;
                  next_st   = ST_ROOT;
               end
            end
         end
         ST_ROOT:
         begin
            if (mem_rsp_valid)
            begin
               fin = 1'b1;
               if (mem_rsp_err)
               begin
                  next_reason = RSN_ROOT_ERR;
               end
               else if (!mem_rsp_data[PRESENT_BIT])
               begin
                  next_reason = RSN_ROOT_NP;
               end
               else if (|mem_rsp_data[ROOT_RSV_HI:1])
               begin
                  next_reason = RSN_ROOT_RSV;
               end
               else
               begin
                  fin       = 1'b0;
                  fetch     = 1'b1;
                  next_addr = {mem_rsp_data[63:PTR_LSB], 12'h000}
                              + 64'({rq_rid[6:0], 5'h00});
                  next_st   = ST_CTX;
               end
            end
         end
         ST_CTX:
         begin
            if (mem_rsp_valid)
            begin
               fin = 1'b1;
               if (mem_rsp_err)
               begin
                  next_reason = RSN_CTX_ERR;
               end
               else if (!widx)
               begin
                  if (!mem_rsp_data[PRESENT_BIT])
                  begin
                     next_reason = RSN_CTX_NP;
                  end
                  else if (mem_rsp_data[CTX_T_LSB +: 3] != T_PLAIN &&
                           mem_rsp_data[CTX_T_LSB +: 3] != T_NESTED)
                  begin
                     next_reason = RSN_BLOCKED;
                  end
                  else
                  begin
                     fin       = 1'b0;
                     fetch     = 1'b1;
                     next_addr = ctx_ptr + 64'h8;
                  end
               end
               else if (aw_fld > 3'h4 || !AW_SUPPORTED[aw_fld] ||
                        (t_fld == T_NESTED && !NEST_SUPPORTED))
               begin
                  next_reason = RSN_CTX_PROG;
               end
               else if (!mem_rsp_data[CTX_PIDE_BIT])
               begin
                  next_reason = RSN_PID_OFF;
               end
               else if (pid_big)
               begin
                  next_reason = RSN_PID_BIG;
               end
               else if (rq_exec && !mem_rsp_data[CTX_ERE_BIT])
               begin
                  next_reason = RSN_EXEC;
               end
               else if (|(pte_addr >> HAW_BITS))
               begin
                  next_reason = RSN_CTX_PROG;
               end
               else
               begin
                  fin       = 1'b0;
                  fetch     = 1'b1;
                  next_addr = pte_addr;
                  next_lvl  = aw_fld + 3'h1;
                  next_st   = ST_PTE;
               end
            end
         end
         ST_PTE:
         begin
            if (mem_rsp_valid)
            begin
               fin = 1'b1;
               if (mem_rsp_err)
               begin
                  next_reason = RSN_CTX_PROG;
               end
               else if (mem_rsp_data[PRESENT_BIT] && rq_priv &&
                        !mem_rsp_data[PTE_SRE_BIT])
               begin
                  next_reason = RSN_SUPV;
               end
               else if (t_fld == T_NESTED)
               begin
                  fin       = 1'b0;
                  fetch     = 1'b1;
                  next_addr = {ctx0[63:PTR_LSB], 12'h000}
                              + 64'({rq_addr[PTR_LSB + SL_IDX_W * lvl
                                              +: SL_IDX_W], 3'h0});
                  next_st   = ST_SLW;
               end
            end
         end
         ST_SLW:
         begin
            if (mem_rsp_valid)
            begin
               fin = 1'b1;
               if (mem_rsp_err)
               begin
                  // the top table comes from the context entry itself
                  next_reason = sl_first ? RSN_CTX_PROG : RSN_SL_ERR;
               end
               else if (lvl != 3'h0)
               begin
                  fin       = 1'b0;
                  fetch     = 1'b1;
                  next_lvl  = lvl - 3'h1;
                  next_addr = sl_addr;
               end
            end
         end
         default:
         begin
            next_st = ST_IDLE;
         end
      endcase
      if (fin)
      begin
         next_st = ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         st       <= ST_IDLE;
         widx     <= 1'b0;
         lvl      <= 3'h0;
         sl_first <= 1'b0;
      end
      else
      begin
         st       <= next_st;
         lvl      <= next_lvl;
         // both flags must survive the wait for the next fetch answer
         widx     <= (st == ST_CTX) && (widx ^ mem_rsp_valid);
         sl_first <= (st == ST_PTE) || (sl_first && !mem_rsp_valid);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         rq_rid   <= 16'h0000;
         rq_pasid <= '0;
         rq_exec  <= 1'b0;
         rq_priv  <= 1'b0;
         rq_addr  <= 64'h0;
      end
      else if (take)
      begin
         rq_rid   <= req_rid;
         rq_pasid <= req_pasid;
         rq_exec  <= req_exec;
         rq_priv  <= req_priv;
         rq_addr  <= req_addr;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         ctx0    <= 64'h0;
         ctx_ptr <= 64'h0;
      end
      else
      begin
         if (st == ST_CTX && mem_rsp_valid && !widx)
         begin
            ctx0 <= mem_rsp_data;
         end
         if (st == ST_ROOT && fetch)
         begin
            ctx_ptr <= next_addr;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         mem_rd_valid <= 1'b0;
         mem_rd_addr  <= 64'h0;
      end
      else
      begin
         mem_rd_valid <= fetch;
         if (fetch)
         begin
            mem_rd_addr <= next_addr;
         end
      end
   end

   // holds because every check path ends the walk on its first fault
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         cpl_valid       <= 1'b0;
         cpl_status      <= CPL_SC;
         fault_valid     <= 1'b0;
         fault_reason    <= RSN_NONE;
         fault_qualified <= 1'b0;
         fault_rid       <= 16'h0000;
         fault_pasid     <= '0;
         last_reason     <= RSN_NONE;
         last_status     <= CPL_SC;
      end
      else
      begin
         cpl_valid   <= fin;
         fault_valid <= fin && (next_reason != RSN_NONE);
         if (fin)
         begin
            cpl_status      <= status_of(next_reason);
            fault_reason    <= next_reason;
            fault_qualified <= qualified_of(next_reason);
            fault_rid       <= cur_rid;
            fault_pasid     <= cur_pasid;
            last_reason     <= next_reason;
            last_status     <= status_of(next_reason);
         end
      end
   end

   always_comb
   begin
      irq_events          = '0;
      irq_events[EV_UR]   = fin && status_of(next_reason) == CPL_UR;
      irq_events[EV_CA]   = fin && status_of(next_reason) == CPL_CA;
      irq_events[EV_DONE] = fin;
   end

   ptfc_irq #(.W(IRQ_W)) u_irq
   (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .events    (irq_events),
      .wr_status (reg_wr && reg_addr == REG_STATUS),
      .wr_mask   (reg_wr && reg_addr == REG_MASK),
      .wdata     (reg_wdata[IRQ_W-1:0]),
      .status    (irq_status),
      .mask      (irq_mask),
      .irq       (irq)
   );

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         rtp_lo <= RTP_RST;
         rtp_hi <= RTP_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == REG_RTP_LO)
         begin
            rtp_lo <= reg_wdata;
         end
         if (reg_addr == REG_RTP_HI)
         begin
            rtp_hi <= reg_wdata;
         end
      end
   end

   // unmapped offsets and cycles without a read return zero
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         reg_rdata <= 32'h0;
      end
      else
      begin
         reg_rdata <= 32'h0;
         if (reg_rd)
         begin
            case (reg_addr)
               REG_RTP_LO: reg_rdata <= rtp_lo;
               REG_RTP_HI: reg_rdata <= rtp_hi;
               REG_STATUS: reg_rdata <= 32'(irq_status);
               REG_MASK:   reg_rdata <= 32'(irq_mask);
               REG_LAST:   reg_rdata <= {21'h0, last_status,
                                         st != ST_IDLE, last_reason};
               default:    reg_rdata <= 32'h0;
            endcase
         end
      end
   end
endmodule // ptfc_top

/* verification/ptfc_checker.sv */
// port assertions for the fault classifier
`timescale 1ns/1ns
module ptfc_checker
import ptfc_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [1:0]  req_addr_type,
   input wire logic        mem_rsp_valid,
   input wire logic [63:0] mem_rsp_data,
   input wire logic        mem_rsp_err,
   input wire logic        cpl_valid,
   input wire logic [1:0]  cpl_status,
   input wire logic        fault_valid,
   input wire logic [7:0]  fault_reason,
   input wire logic        fault_qualified
);
   logic first_rsp;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // armed at each take, so the next answer is always the root entry
   always_ff @(posedge sys_clk)
      if (!nrst || mem_rsp_valid)
         first_rsp <= 1'b0;
      else if (req_valid && req_ready)
         first_rsp <= 1'b1;
   fault_cpl_a: assert property (
      fault_valid |-> cpl_valid && fault_reason != 8'h00)
      else $error("stray fault pulse");
   ur_status_a: assert property (
      cpl_valid && fault_reason inside {8'h01, 8'h1B, 8'h02, 8'h0D, 8'h10,
      8'h11, 8'h19, 8'h1A} |-> cpl_status == CPL_UR && fault_valid)
      else $error("block not unsupported");
   ca_status_a: assert property (
      cpl_valid && fault_reason inside {8'h03, 8'h07, 8'h08, 8'h09, 8'h0A}
      |-> cpl_status == CPL_CA && fault_valid)
      else $error("error not abort");
   nonqual_flag_a: assert property (
      cpl_valid && fault_reason inside {8'h01, 8'h1B, 8'h08, 8'h09, 8'h0A}
      |-> !fault_qualified)
      else $error("wrongly qualified");
   qual_flag_a: assert property (
      cpl_valid && fault_reason inside {8'h02, 8'h03, 8'h07, 8'h0D, 8'h10,
      8'h11, 8'h19, 8'h1A} |-> fault_qualified)
      else $error("wrongly unqualified");
   plain_pass_a: assert property (
      req_valid && req_ready && req_addr_type != AT_XLATE_REQ |=>
      cpl_valid && !fault_valid && cpl_status == CPL_SC)
      else $error("plain request not passed");
   root_err_a: assert property (
      first_rsp && mem_rsp_valid && mem_rsp_err |=>
      cpl_valid && fault_reason == RSN_ROOT_ERR)
      else $error("root fetch error missed");
   root_absent_a: assert property (
      first_rsp && mem_rsp_valid && !mem_rsp_err && !mem_rsp_data[0] |=>
      cpl_valid && fault_reason == RSN_ROOT_NP)
      else $error("absent root missed");
endmodule // ptfc_checker

/* verification/ptfc_mem_model.sv */
// memory partner answering entry fetches from a sparse word table
`timescale 1ns/1ns
module ptfc_mem_model
(
   input  wire logic        sys_clk,
   input  wire logic        mem_rd_valid,
   input  wire logic [63:0] mem_rd_addr,
   output bit               mem_rsp_valid,
   output bit        [63:0] mem_rsp_data,
   output bit               mem_rsp_err
);
   bit   [63:0] words [logic [63:0]];
   bit          bad   [logic [63:0]];
   logic [63:0] addr;
   int          wait_n = 0;
   int          lat = 1;
   // latency alternates 1 and 3; idle data toggles so stale words never match
   always @(posedge sys_clk)
   begin
      mem_rsp_valid <= 1'b0;
      mem_rsp_err   <= 1'b0;
      mem_rsp_data  <= ~mem_rsp_data;
      if (mem_rd_valid)
      begin
         addr   <= mem_rd_addr;
         wait_n <= lat;
         lat    <= 4 - lat;
      end
      else if (wait_n > 0)
      begin
         wait_n <= wait_n - 1;
         if (wait_n == 1)
         begin
            mem_rsp_valid <= 1'b1;
            mem_rsp_data  <= words.exists(addr) ? words[addr] : 64'h0;
            mem_rsp_err   <= bad.exists(addr);
         end
      end
   end
endmodule // ptfc_mem_model

/* verification/testbench.sv */
// self-checking bench for the process-id translation fault classifier
`timescale 1ns/1ns
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
   fail_count++; $display("Error %s expected %0h seen %0h", nm, e, s); end end
module testbench;
   import ptfc_pkg::*;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [4:0]  reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, irq, req_ready;
   logic        req_valid = 1'b0, req_exec = 1'b0, req_priv = 1'b0;
   logic        req_pasid_present = 1'b0, cpl_valid, fault_valid;
   logic [1:0]  req_addr_type = 2'h0, cpl_status;
   logic [19:0] req_pasid = 20'h0, fault_pasid;
   logic [15:0] req_rid = 16'h0001, fault_rid;
   logic [63:0] req_addr = 64'h0, mem_rd_addr, mem_rsp_data;
   logic        mem_rd_valid, mem_rsp_valid, mem_rsp_err, fault_qualified;
   logic [7:0]  fault_reason;
   int          fail_count = 0, num_checks = 0, cyc = 0;
   ptfc_top ptfc_top_inst (.*);
   ptfc_mem_model ptfc_mem_model_inst (.*);
   always #25 sys_clk = ~sys_clk;
   task automatic give_verdict();
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic reg_w(input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      #1;
   endtask
   task automatic reg_r(input logic [4:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask
   task automatic run(input logic [1:0] at, input logic pp, ex, pr,
                      input logic [19:0] id, input logic [7:0] rsn);
      logic [1:0] st;
      int         n;
      st = rsn == 8'h00 ? CPL_SC : rsn inside {8'h03, 8'h07, 8'h08, 8'h09,
           8'h0A} ? CPL_CA : CPL_UR;
      @(posedge sys_clk);
      req_valid         <= 1'b1;
      req_addr_type     <= at;
      req_pasid_present <= pp;
      req_exec          <= ex;
      req_priv          <= pr;
      req_pasid         <= id;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      #1;
      for (n = 0; n < 60 && cpl_valid !== 1'b1; n++)
      begin
         @(posedge sys_clk);
         #1;
      end
      `CHK("cpl_valid", 1'b1, cpl_valid)
      `CHK("cpl_status", st, cpl_status)
      `CHK("fault_reason", rsn, fault_reason)
      `CHK("fault_valid", rsn != 8'h00, fault_valid)
      `CHK("fault_pasid", id, fault_pasid)
      `CHK("fault_rid", req_rid, fault_rid)
   endtask
   task automatic base();
      ptfc_mem_model_inst.bad.delete();
      ptfc_mem_model_inst.words[64'h1000] = 64'h2001;
      ptfc_mem_model_inst.words[64'h3000] = 64'h5000;
      ptfc_mem_model_inst.words[64'h5000] = 64'h6000;
   endtask
   task automatic row(input logic [63:0] c0, c1, pe, bad,
                      input logic ex, pr, input logic [19:0] id,
                      input logic [7:0] rsn);
      base();
      ptfc_mem_model_inst.words[64'h2020] = c0;
      ptfc_mem_model_inst.words[64'h2028] = c1;
      ptfc_mem_model_inst.words[64'h4010] = pe;
      if (bad != 64'h0)
         ptfc_mem_model_inst.bad[bad] = 1'b1;
      run(2'h1, 1'b1, ex, pr, id, rsn);
   endtask
   task automatic t_regs();
      reg_r(REG_RTP_LO, 32'h0);
      reg_r(REG_MASK, 32'h0);
      reg_r(5'h14, 32'h0);
      reg_w(REG_RTP_LO, 32'h1800);
      reg_r(REG_RTP_LO, 32'h1800);
      base();
      ptfc_mem_model_inst.words[64'h1000] = 64'h2000;
      run(2'h1, 1'b1, 1'b0, 1'b0, 20'h2, 8'h01);
      reg_r(REG_LAST, 32'h201);
      `CHK("irq", 1'b0, irq)
      reg_w(REG_MASK, 32'h1);
      `CHK("irq", 1'b1, irq)
      reg_r(REG_STATUS, 32'h5);
      reg_w(REG_STATUS, 32'h1);
      `CHK("irq", 1'b0, irq)
      reg_r(REG_STATUS, 32'h4);
   endtask
   task automatic t_root();
      run(2'h2, 1'b1, 1'b0, 1'b0, 20'h2, 8'h00);
      run(2'h1, 1'b0, 1'b0, 1'b0, 20'h2, 8'h00);
      base();
      ptfc_mem_model_inst.words[64'h1000] = 64'h2003;
      run(2'h1, 1'b1, 1'b0, 1'b0, 20'h2, 8'h0A);
      ptfc_mem_model_inst.bad[64'h1000] = 1'b1;
      run(2'h1, 1'b1, 1'b0, 1'b0, 20'h2, 8'h08);
      reg_w(REG_RTP_LO, 32'h1000);
      run(2'h1, 1'b1, 1'b0, 1'b0, 20'h2, 8'h1B);
      reg_w(REG_RTP_LO, 32'h1800);
   endtask
   task automatic t_ctx();
      row(16'h3004, 16'h4019, 4'h3, 4'h0, 1'b0, 1'b0, 8'h02, 8'h02);
      row(16'h3009, 16'h4019, 4'h3, 4'h0, 1'b0, 1'b0, 8'h02, 8'h0D);
      row(16'h3005, 16'h4011, 4'h3, 4'h0, 1'b0, 1'b0, 8'h02, 8'h10);
      row(16'h3005, 16'h4019, 4'h3, 4'h0, 1'b0, 1'b0, 8'h20, 8'h11);
      row(16'h3005, 16'h4009, 4'h3, 4'h0, 1'b1, 1'b0, 8'h02, 8'h19);
      row(16'h3005, 16'h4019, 4'h1, 4'h0, 1'b0, 1'b1, 8'h02, 8'h1A);
      row(16'h3005, 16'h4019, 4'h3, 16'h2020, 1'b0, 1'b0, 8'h02, 8'h09);
      row(16'h3005, 16'h401B, 4'h3, 4'h0, 1'b0, 1'b0, 8'h02, 8'h03);
      row(16'h3005, 16'h4019, 4'h3, 16'h4010, 1'b0, 1'b0, 8'h02, 8'h03);
      row(16'h3005, 40'h8000004019, 4'h3, 4'h0, 1'b0, 1'b0, 8'h2, 8'h03);
      row(16'h3005, 16'h4019, 4'h3, 4'h0, 1'b0, 1'b0, 8'h02, 8'h00);
   endtask
   task automatic t_nest();
      row(16'h3015, 16'h4019, 4'h3, 16'h3000, 1'b0, 1'b0, 8'h02, 8'h03);
      row(16'h3015, 16'h4019, 4'h3, 16'h5000, 1'b0, 1'b0, 8'h02, 8'h07);
      row(16'h3015, 16'h4019, 4'h3, 4'h0, 1'b0, 1'b0, 8'h02, 8'h00);
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      t_regs();
      t_root();
      t_ctx();
      t_nest();
      give_verdict();
   end
endmodule // testbench
bind ptfc_top ptfc_checker ptfc_checker_inst (.*);
